// ==== pkg/adc_conv_pkg.sv ====
`default_nettype none
package adc_conv_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;
  localparam int CNT_W         = 11;

  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RESULT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 8'h0c;

  // Status field positions
  localparam int ST_BUSY      = 0;
  localparam int ST_FRAME     = 1;
  localparam int ST_UNDERRUN  = 2;
  localparam int ST_LEVEL_LSB = 8;

  // Pin synchroniser lanes
  localparam int PIN_START = 0;
  localparam int PIN_XCLK  = 1;
  localparam int PIN_CHAIN = 2;
  localparam int PIN_CS    = 3;
  localparam int PIN_N     = 4;
  localparam logic [PIN_N-1:0] PIN_RESET = 4'h9;

  typedef enum logic [1:0] {MODE_FAST, MODE_NORMAL, MODE_LOWPWR} tmode_e;
  typedef enum logic [1:0] {IF_PARALLEL, IF_MASTER_RDC, IF_MASTER_RAC, IF_SLAVE} iface_e;

  typedef struct packed {
    logic [1:0] div;
    iface_e     iface;
    tmode_e     mode;
  } ctrl_s;

  localparam int    CTRL_W     = $bits(ctrl_s);
  localparam ctrl_s CTRL_RESET = '{div: 2'h0, iface: IF_PARALLEL, mode: MODE_FAST};

  // Timing figures in ns
  localparam int T_CONV_NS [3]         = '{750, 1000, 1250};
  localparam int T_BUSY_RISE_NS        = 30;
  localparam int T_END_TO_BUSY_LOW_NS  = 10;
  localparam int T_DATA_TO_BUSY_LOW_NS = 45;
  localparam int T_RDC_SYNC_NS [3]     = '{25, 275, 525};
  localparam int T_SYNC_TO_BUSY_LOW_NS = 25;
  localparam int T_BCLK_MIN_NS [4]     = '{25, 50, 100, 200};
  localparam int T_LEAD_MIN_NS [4]     = '{3, 17, 17, 17};
  localparam int T_TAIL_MIN_NS [4]     = '{3, 60, 140, 300};
  localparam int T_RAC_BUSY_MAX_NS [4] = '{1500, 2000, 3000, 5250};

  // Pin edge to internal event, in cycles
  localparam int SYNC_LAT = 3;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int HOLD_CYC = (cyc_up(T_DATA_TO_BUSY_LOW_NS) > cyc_up(T_END_TO_BUSY_LOW_NS)) ?
                            cyc_up(T_DATA_TO_BUSY_LOW_NS) : cyc_up(T_END_TO_BUSY_LOW_NS);
  localparam int POST_CYC      = cyc_up(T_SYNC_TO_BUSY_LOW_NS);
  localparam int BUSY_RISE_CYC = cyc_dn(T_BUSY_RISE_NS);

  // Margin keeps the pin-to-pin busy width under the longest time
  function automatic int conv_cyc(input tmode_e m);
    return cyc_dn(T_CONV_NS[int'(m)]) - HOLD_CYC - SYNC_LAT - 2;
  endfunction

  function automatic int rdc_cyc(input tmode_e m);
    int c;
    c = cyc_up(T_RDC_SYNC_NS[int'(m)]) - SYNC_LAT;
    return (c < 1) ? 1 : c;
  endfunction
endpackage
`default_nettype wire

// ==== rtl/adc_conv_readout.sv ====
// Behaviour
// RULE_01 - Host spaces start strobes by 1, 1.25 or 1.5 us per mode.
// RULE_02 - Fastest mode only: host starts again within 1 ms.
// RULE_03 - Busy rises within 30 ns of start strobe falling.
// RULE_04 - Busy lasts at most 0.75, 1 or 1.25 us, except read-after-convert.
// RULE_05 - Busy drops at least 10 ns after the conversion ends.
// RULE_06 - Parallel result valid at most 0.75, 1 or 1.25 us after start.
// RULE_07 - Parallel result valid at least 45 ns before busy falls.
// RULE_08 - Parallel bus request drives valid data within 40 ns.
// RULE_09 - Select low enables marker, bit clock and serial data within 10 ns.
// RULE_10 - Select high releases marker, bit clock and serial data within 10 ns.
// RULE_11 - Read-during-convert marker rises 25, 275 or 525 ns after start.
// RULE_12 - Marker rises before the first bit clock edge, at least 3 ns.
// RULE_13 - Marker falls after the last bit clock edge, at least 3 ns.
// RULE_14 - Divider code sets bit clock period 25, 50, 100 or 200 ns minimum.
// RULE_15 - Read-after-convert marker rises when the conversion completes.
// RULE_16 - Read-after-convert busy falls about 25 ns after marker falls.
// RULE_17 - Read-after-convert fastest busy at most 1.5, 2, 3, 5.25 us per divider.
// RULE_18 - Each master frame carries exactly one 16-bit result.
// RULE_19 - Slave bit clock from host: period 25 ns, phases 10 ns minimum.
`timescale 1ns/100ps
`default_nettype none

module fifo_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  localparam int AW   = $clog2(DEPTH),
  localparam int LW   = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [LW-1:0]    level
);
  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [LW-1:0]    next_level;
  logic             push, pop;

  assign in_ready  = (level != LW'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_level  = level;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_level = level + 1'b1;
    end else if (pop && !push) begin
      next_level = level - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem    <= '{default: '0};
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level  <= next_level;
    end
  end
endmodule

module adc_conv_readout
  import adc_conv_pkg::*;
#(
  parameter int RES_W      = 16,
  parameter int FIFO_DEPTH = 32,
  localparam int LW        = $clog2(FIFO_DEPTH + 1)
) (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic                   pready,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pslverr,
  // Conversion pins
  input  wire logic              convert_start_n,
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  output logic                   busy,
  // Parallel bus
  output logic      [RES_W-1:0]  par_data,
  output logic                   par_data_oe_n,
  // Serial link
  output logic                   frame_sync,
  output logic                   frame_sync_oe_n,
  output logic                   bit_clk_out,
  output logic                   bit_clk_oe_n,
  output logic                   serial_result_out,
  output logic                   serial_result_oe_n,
  input  wire logic              ext_bit_clk,
  input  wire logic              serial_chain_in,
  // Sample source
  input  wire logic [RES_W-1:0]  sample_data,
  input  wire logic              sample_valid,
  output logic                   sample_ready
);
  typedef enum {C_IDLE, C_CONV, C_HOLD, C_RAC_XFER, C_RAC_POST} conv_state_e;
  typedef enum {S_IDLE, S_DELAY, S_LEAD, S_LOW, S_HIGH, S_TAIL} ser_state_e;

  ctrl_s            ctrl, next_ctrl;
  logic [PIN_N-1:0] pin_s1, pin_s2, pin_s3, pin_stable, next_stable;
  logic [DATA_W-1:0] next_prdata;
  logic [DATA_W-1:0] conv_count, next_conv_count;
  logic [RES_W-1:0] result, next_result, out_shift, next_out_shift;
  logic [RES_W-1:0] fifo_data;
  logic [LW-1:0]    fifo_level;
  logic             fifo_valid, fifo_pop;
  conv_state_e      conv_state, next_conv_state;
  ser_state_e       ser_state, next_ser_state;
  logic [CNT_W-1:0] conv_cnt, next_conv_cnt, ser_cnt, next_ser_cnt, busy_cyc;
  logic [4:0]       ser_bit, next_ser_bit;
  logic             next_busy, frame, next_frame, bclk, next_bclk;
  logic             underrun, next_underrun, stalled, next_stalled;
  logic             start_fall, xclk_fall, ser_go, ser_done, result_load;
  logic             is_rac, is_master, wr_en, rd_setup;
  logic [CNT_W-1:0] ser_delay, bclk_low, bclk_high;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_RESULT) || (a == REG_COUNT);
  endfunction

  fifo_buf #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .level     (fifo_level)
  );

  // Pin inputs: three stages, a level counts once stages two and three agree
  assign next_stable = (pin_s2 & pin_s3) | (pin_stable & (pin_s2 ^ pin_s3));
  assign start_fall  = pin_stable[PIN_START] && !next_stable[PIN_START];
  // Host-made bit clock is oversampled, so its phases must cover the sync window
  assign xclk_fall   = pin_stable[PIN_XCLK] && !next_stable[PIN_XCLK];  // RULE_19

  assign is_rac    = (ctrl.iface == IF_MASTER_RAC);
  assign is_master = (ctrl.iface == IF_MASTER_RDC) || is_rac;

  // APB: zero wait states, read data captured in the setup cycle
  assign pready   = psel && penable;
  assign pslverr  = pready && !addr_mapped(paddr);
  assign wr_en    = pready && pwrite && addr_mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    next_ctrl   = ctrl;
    next_prdata = prdata;
    if (wr_en && paddr == REG_CTRL) begin
      next_ctrl = ctrl_s'(pwdata[CTRL_W-1:0]);
      // Unused mode code falls back to the slowest mode
      if (next_ctrl.mode != MODE_FAST && next_ctrl.mode != MODE_NORMAL) begin
        next_ctrl.mode = MODE_LOWPWR;
      end
    end
    if (rd_setup) begin
      next_prdata = '0;
      case (paddr)
        REG_CTRL:   next_prdata[CTRL_W-1:0] = ctrl;
        REG_STATUS: begin
          next_prdata[ST_BUSY]                       = busy;
          next_prdata[ST_FRAME]                      = frame;
          next_prdata[ST_UNDERRUN]                   = underrun;
          next_prdata[ST_LEVEL_LSB +: LW]            = fifo_level;
        end
        REG_RESULT: next_prdata[RES_W-1:0] = result;
        REG_COUNT:  next_prdata = conv_count;
        default:    next_prdata = '0;
      endcase
    end
  end

  // Conversion sequencer
  always_comb begin
    next_conv_state = conv_state;
    next_conv_cnt   = conv_cnt;
    next_busy       = busy;
    next_result     = result;
    next_conv_count = conv_count;
    next_stalled    = stalled;
    next_underrun   = underrun;
    fifo_pop        = 1'b0;
    result_load     = 1'b0;
    ser_go          = 1'b0;
    ser_delay       = CNT_W'(rdc_cyc(ctrl.mode));
    if (wr_en && paddr == REG_STATUS && pwdata[ST_UNDERRUN]) begin
      next_underrun = 1'b0;
    end
    case (conv_state)
      C_IDLE: begin
        // Strobes while busy are dropped, relying on host spacing
        if (start_fall) begin  // RULE_01
          next_conv_state = C_CONV;
          next_busy       = 1'b1;  // RULE_03
          next_stalled    = 1'b0;
          next_conv_cnt   = CNT_W'(conv_cyc(ctrl.mode));  // RULE_04 RULE_06
          // Previous result leaves while this one converts
          ser_go          = (ctrl.iface == IF_MASTER_RDC);  // RULE_11
        end
      end
      C_CONV: begin
        if (conv_cnt != '0) begin
          next_conv_cnt = conv_cnt - 1'b1;
        end else if (fifo_valid) begin
          fifo_pop        = 1'b1;
          result_load     = 1'b1;
          next_result     = fifo_data;
          next_conv_count = conv_count + 1'b1;
          if (is_rac) begin
            next_conv_state = C_RAC_XFER;  // RULE_15
            ser_go          = 1'b1;
            ser_delay       = CNT_W'(1);
          end else begin
            next_conv_state = C_HOLD;
            next_conv_cnt   = CNT_W'(HOLD_CYC - 1);  // RULE_05 RULE_07
          end
        end else begin
          // Empty source stalls the conversion; flagged for software
          next_stalled  = 1'b1;
          next_underrun = 1'b1;
        end
      end
      C_HOLD: begin
        if (conv_cnt != '0) begin
          next_conv_cnt = conv_cnt - 1'b1;
        end else begin
          next_conv_state = C_IDLE;
          next_busy       = 1'b0;
        end
      end
      C_RAC_XFER: begin
        if (ser_done) begin
          next_conv_state = C_RAC_POST;
          next_conv_cnt   = CNT_W'(POST_CYC - 1);  // RULE_16
        end
      end
      C_RAC_POST: begin
        if (conv_cnt != '0) begin
          next_conv_cnt = conv_cnt - 1'b1;
        end else begin
          next_conv_state = C_IDLE;
          next_busy       = 1'b0;  // RULE_16 RULE_17
        end
      end
      default: begin
        next_conv_state = C_IDLE;
        next_busy       = 1'b0;
      end
    endcase
  end

  // Bit clock phases from the divider code
  assign bclk_high = CNT_W'(cyc_up(T_BCLK_MIN_NS[ctrl.div]) - cyc_up(T_BCLK_MIN_NS[ctrl.div]) / 2);  // RULE_14
  assign bclk_low  = CNT_W'(cyc_up(T_BCLK_MIN_NS[ctrl.div]) / 2);  // RULE_14
  assign ser_done  = (ser_state == S_TAIL) && (ser_cnt == '0);

  // Serial engine, shared shifter for master and slave
  always_comb begin
    next_ser_state = ser_state;
    next_ser_cnt   = ser_cnt;
    next_ser_bit   = ser_bit;
    next_frame     = frame;
    next_bclk      = bclk;
    next_out_shift = out_shift;
    if (ctrl.iface == IF_SLAVE) begin
      if (result_load) begin
        next_out_shift = next_result;
      end else if (xclk_fall && !pin_stable[PIN_CS]) begin
        // Chain input follows the result for daisy chaining
        next_out_shift = {out_shift[RES_W-2:0], pin_stable[PIN_CHAIN]};
      end
    end
    case (ser_state)
      S_IDLE: begin
        if (ser_go) begin
          next_out_shift = is_rac ? fifo_data : result;
          next_ser_cnt   = ser_delay - 1'b1;
          next_ser_state = S_DELAY;
        end
      end
      S_DELAY: begin
        if (ser_cnt != '0) begin
          next_ser_cnt = ser_cnt - 1'b1;
        end else begin
          next_frame     = 1'b1;  // RULE_11 RULE_15
          next_ser_cnt   = CNT_W'(cyc_up(T_LEAD_MIN_NS[ctrl.div]) - 1);  // RULE_12
          next_ser_state = S_LEAD;
        end
      end
      S_LEAD: begin
        if (ser_cnt != '0) begin
          next_ser_cnt = ser_cnt - 1'b1;
        end else begin
          next_ser_bit   = '0;
          next_ser_cnt   = bclk_low - 1'b1;
          next_ser_state = S_LOW;
        end
      end
      S_LOW: begin
        if (ser_cnt != '0) begin
          next_ser_cnt = ser_cnt - 1'b1;
        end else begin
          next_bclk      = 1'b1;
          next_ser_cnt   = bclk_high - 1'b1;
          next_ser_state = S_HIGH;
        end
      end
      S_HIGH: begin
        if (ser_cnt != '0) begin
          next_ser_cnt = ser_cnt - 1'b1;
        end else begin
          next_bclk = 1'b0;
          if (ser_bit == 5'(RES_W - 1)) begin  // RULE_18
            next_ser_cnt   = CNT_W'(cyc_up(T_TAIL_MIN_NS[ctrl.div]) - 1);  // RULE_13
            next_ser_state = S_TAIL;
          end else begin
            next_out_shift = {out_shift[RES_W-2:0], 1'b0};
            next_ser_bit   = ser_bit + 1'b1;
            next_ser_cnt   = bclk_low - 1'b1;
            next_ser_state = S_LOW;
          end
        end
      end
      S_TAIL: begin
        if (ser_cnt != '0) begin
          next_ser_cnt = ser_cnt - 1'b1;
        end else begin
          next_frame     = 1'b0;  // RULE_18
          next_ser_state = S_IDLE;
        end
      end
      default: begin
        next_ser_state = S_IDLE;
        next_frame     = 1'b0;
        next_bclk      = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1     <= PIN_RESET;
      pin_s2     <= PIN_RESET;
      pin_s3     <= PIN_RESET;
      pin_stable <= PIN_RESET;
      ctrl       <= CTRL_RESET;
      prdata     <= '0;
      conv_state <= C_IDLE;
      conv_cnt   <= '0;
      busy       <= 1'b0;
      result     <= '0;
      conv_count <= '0;
      stalled    <= 1'b0;
      underrun   <= 1'b0;
      ser_state  <= S_IDLE;
      ser_cnt    <= '0;
      ser_bit    <= '0;
      frame      <= 1'b0;
      bclk       <= 1'b0;
      out_shift  <= '0;
    end else begin
      pin_s1     <= {cs_n, serial_chain_in, ext_bit_clk, convert_start_n};
      pin_s2     <= pin_s1;
      pin_s3     <= pin_s2;
      pin_stable <= next_stable;
      ctrl       <= next_ctrl;
      prdata     <= next_prdata;
      conv_state <= next_conv_state;
      conv_cnt   <= next_conv_cnt;
      busy       <= next_busy;
      result     <= next_result;
      conv_count <= next_conv_count;
      stalled    <= next_stalled;
      underrun   <= next_underrun;
      ser_state  <= next_ser_state;
      ser_cnt    <= next_ser_cnt;
      ser_bit    <= next_ser_bit;
      frame      <= next_frame;
      bclk       <= next_bclk;
      out_shift  <= next_out_shift;
    end
  end

  // Enables follow the pins directly: a synchroniser would miss 10 ns and 40 ns
  assign par_data           = result;
  assign par_data_oe_n      = cs_n || rd_n || (ctrl.iface != IF_PARALLEL);  // RULE_08
  assign frame_sync         = frame;
  assign bit_clk_out        = bclk;
  assign serial_result_out  = out_shift[RES_W-1];
  assign frame_sync_oe_n    = cs_n || !is_master;  // RULE_09 RULE_10
  assign bit_clk_oe_n       = cs_n || !is_master;  // RULE_09 RULE_10
  assign serial_result_oe_n = cs_n || (ctrl.iface == IF_PARALLEL);  // RULE_09 RULE_10

  // Checks
  logic [4:0] edge_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cyc  <= '0;
      edge_seen <= '0;
    end else begin
      busy_cyc  <= busy ? busy_cyc + 1'b1 : '0;
      edge_seen <= !frame ? '0 : (bclk && !next_bclk) ? edge_seen + 1'b1 : edge_seen;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_busy_rise: assert property ($fell(convert_start_n) && conv_state == C_IDLE && !busy && convert_start_n == 1'b0 ##1 !convert_start_n[*3] |-> ##[0:3] busy) else $error("busy late after start"); // RULE_03
  a_busy_width: assert property (busy && !is_rac && !stalled |-> int'(busy_cyc) <= cyc_dn(T_CONV_NS[ctrl.mode]) - SYNC_LAT) else $error("busy too long"); // RULE_04
  a_data_lead: assert property (result_load && !is_rac |=> busy[*8] ##1 busy ##1 !busy) else $error("data not ahead of busy fall"); // RULE_07
  a_par_drive: assert property (!cs_n && !rd_n && ctrl.iface == IF_PARALLEL |-> !par_data_oe_n && par_data == result) else $error("parallel bus not driven"); // RULE_08
  a_ser_release: assert property (cs_n |-> frame_sync_oe_n && bit_clk_oe_n && serial_result_oe_n) else $error("serial pins not released"); // RULE_10
  a_ser_enable: assert property (!cs_n && is_master |-> !frame_sync_oe_n && !bit_clk_oe_n && !serial_result_oe_n) else $error("serial pins not enabled"); // RULE_09
  a_rdc_sync: assert property (start_fall && conv_state == C_IDLE && ctrl.iface == IF_MASTER_RDC && ser_state == S_IDLE |-> ##[1:106] frame) else $error("marker late"); // RULE_11
  a_lead_edge: assert property ($rose(bclk) |-> frame && $past(frame) && !$past(bclk, 2)) else $error("bit clock edge without lead"); // RULE_12
  a_tail_edge: assert property ($fell(frame) |-> !$past(bclk) && edge_seen == 5'(RES_W)) else $error("frame ended badly"); // RULE_13 RULE_18
  a_rac_sync: assert property (result_load && is_rac |-> ##[1:3] frame) else $error("marker late after convert"); // RULE_15
  a_rac_busy: assert property ($fell(frame) && is_rac |-> busy[*5] ##1 !busy) else $error("busy fall misplaced"); // RULE_16
  a_rac_width: assert property (busy && is_rac && !stalled && ctrl.mode == MODE_FAST |-> int'(busy_cyc) <= cyc_dn(T_RAC_BUSY_MAX_NS[ctrl.div]) - SYNC_LAT) else $error("busy too long in read after convert"); // RULE_17

  c_parallel: cover property (result_load && ctrl.iface == IF_PARALLEL ##[1:20] $fell(busy));
  c_rdc_frame: cover property ($fell(frame) && ctrl.iface == IF_MASTER_RDC);
  c_rac_frame: cover property ($fell(frame) && is_rac ##[1:10] $fell(busy));
  c_slave_shift: cover property (xclk_fall && ctrl.iface == IF_SLAVE && !cs_n);
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic pclk,
  // Request from the bench
  input  wire logic go,
  // Start pin
  output logic      convert_start_n
);
  int gap = 0;
  initial convert_start_n = 1'b1;
  // Four-cycle strobe so the pin filter sees it, then hold off for the slowest mode
  always @(posedge pclk) begin
    if (go && gap >= 300) begin
      convert_start_n <= 1'b0;
      gap             <= 0;
    end else begin
      gap <= gap + 1;
      if (gap >= 3) convert_start_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_adc_conv_readout.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_adc_conv_readout;
  import adc_conv_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, cs_n, rd_n, go, sample_valid, err, xclk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] sample_data, par_data, last, q[$];
  wire logic   pready, pslverr, busy, par_data_oe_n, frame_sync, frame_sync_oe_n;
  wire logic   bit_clk_out, bit_clk_oe_n, serial_result_out, serial_result_oe_n;
  wire logic   convert_start_n, sample_ready;
  int          miscompares, checked, cycles, n;

  adc_conv_readout dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n),
    .busy(busy), .par_data(par_data), .par_data_oe_n(par_data_oe_n),
    .frame_sync(frame_sync), .frame_sync_oe_n(frame_sync_oe_n), .bit_clk_out(bit_clk_out),
    .bit_clk_oe_n(bit_clk_oe_n), .serial_result_out(serial_result_out),
    .serial_result_oe_n(serial_result_oe_n), .ext_bit_clk(xclk), .serial_chain_in(1'b0),
    .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready));
  host_model host_u (.pclk(pclk), .go(go), .convert_start_n(convert_start_n));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test;
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic push(input int k);
    repeat (k) begin
      @(posedge pclk);
      sample_data <= 16'($urandom);
      sample_valid <= 1'b1;
      do @(posedge pclk); while (sample_ready !== 1'b1);
      q.push_back(sample_data);
      sample_valid <= 1'b0;
    end
  endtask

  task automatic conv(input int m, input iface_e f, input int d);
    logic [15:0] bits, pd, want;
    logic        pb;
    int          w, e, fl, hold, pr;
    apb(1'b1, REG_CTRL, 32'(m + 4 * int'(f) + 16 * d));
    w = 0; e = 0; fl = 0; hold = 0; pr = 0; pb = 1'b0; pd = par_data; bits = '0;
    go <= 1'b1;
    while (convert_start_n !== 1'b0 && w < 400) begin @(negedge pclk); w++; end
    w = 0;
    while (busy !== 1'b1 && w < 9) begin @(negedge pclk); w++; end
    chk("busy_rise", 1, 32'(w <= 6));
    go <= 1'b0;
    w = 0;
    while (busy === 1'b1 && w < 1200) begin
      @(negedge pclk);
      w++;
      pr++;
      if (bit_clk_out && !pb && frame_sync) begin
        if (e > 0) chk("bit_period", 1, 32'(pr * 5 >= T_BCLK_MIN_NS[d]));
        bits = {bits[14:0], serial_result_out};
        e++;
        pr = 0;
      end
      pb = bit_clk_out;
      fl = frame_sync ? 0 : fl + 1;
      hold = (par_data !== pd) ? 0 : hold + 1;
      pd = par_data;
    end
    want = q.pop_front();
    chk("par_data", want, par_data);
    chk("par_oe_n", 32'(f != IF_PARALLEL), par_data_oe_n);
    chk("data_hold", 1, 32'(hold >= 9));
    if (f == IF_MASTER_RAC) begin
      chk("busy_tail", 6, fl);
      chk("rac_width", 1, 32'(w * 5 <= T_RAC_BUSY_MAX_NS[d]));
    end else chk("busy_width", 1, 32'(w * 5 <= T_CONV_NS[m]));
    if (f == IF_MASTER_RAC || f == IF_MASTER_RDC) begin
      chk("ser_oe_n", 0, {frame_sync_oe_n, bit_clk_oe_n, serial_result_oe_n});
      chk("bit_count", 16, e);
      chk("ser_word", (f == IF_MASTER_RAC) ? want : last, bits);
    end
    if (f == IF_SLAVE) begin
      // Host clock phases of six cycles cover the pin filter
      for (int i = 0; i < 16; i++) begin
        repeat (6) @(posedge pclk);
        bits = {bits[14:0], serial_result_out};
        xclk <= 1'b1;
        repeat (6) @(posedge pclk);
        xclk <= 1'b0;
      end
      chk("slave_word", want, bits);
    end
    apb(1'b0, REG_RESULT, 0);
    chk("result", want, r);
    last = want;
    n++;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Ceiling leaves ample room over roughly 11k cycles of traffic
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    cs_n = 1'b0; rd_n = 1'b0; go = 1'b0; sample_valid = 1'b0; sample_data = '0; last = '0;
    xclk = 1'b0;
    void'($urandom(58));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, REG_CTRL, 0);
    chk("ctrl_reset", 0, r);
    apb(1'b0, 8'h20, 0);
    chk("slverr", 1, err);
    push(32);
    apb(1'b0, REG_STATUS, 0);
    chk("level_full", 32, r[13:8]);
    chk("full_ready", 0, sample_ready);
    for (int m = 0; m < 3; m++) conv(m, IF_PARALLEL, 0);
    for (int d = 0; d < 4; d++) conv(0, IF_MASTER_RAC, d);
    conv(1, IF_MASTER_RDC, 0);
    @(posedge pclk);
    cs_n <= 1'b1;
    @(negedge pclk);
    chk("released", 7, {frame_sync_oe_n, bit_clk_oe_n, serial_result_oe_n});
    cs_n <= 1'b0;
    conv(2, IF_SLAVE, 0);
    while (q.size() > 0) conv($urandom % 3, IF_PARALLEL, 0);
    // Empty source: conversion stalls until a sample arrives
    go <= 1'b1;
    wait (busy === 1'b1);
    @(posedge pclk);
    go <= 1'b0;
    repeat (300) @(posedge pclk);
    apb(1'b0, REG_STATUS, 0);
    chk("stall_status", 32'h5, r);
    push(1);
    wait (busy === 1'b0);
    chk("stall_data", q.pop_front(), par_data);
    apb(1'b1, REG_STATUS, 32'h4);
    apb(1'b0, REG_STATUS, 0);
    chk("underrun_clr", 0, r);
    n++;
    apb(1'b0, REG_STATUS, 0);
    chk("level_empty", 0, r[13:8]);
    apb(1'b0, REG_COUNT, 0);
    chk("count", n, r);
    stop_test();
  end
endmodule
`default_nettype wire
